// >>> lmp_pkg.sv
// Shared constants for the low-power memory command-timing model.
// Assumes one system clock at 50 MHz; all latencies are in clock cycles.
package lmp_pkg;
   // Clock period in picoseconds
   localparam int CLK_PERIOD_PS = 20000;
   // Command codes on the abstract command bus
   typedef enum logic [3:0] {
      LMP_CMD_NOP   = 4'h0,
      LMP_CMD_READ  = 4'h1,
      LMP_CMD_WRITE = 4'h2,
      LMP_CMD_ACT   = 4'h3,
      LMP_CMD_PRE   = 4'h4,
      LMP_CMD_MRR   = 4'h5,
      LMP_CMD_MRW   = 4'h6,
      LMP_CMD_ZQ    = 4'h7,
      LMP_CMD_SREF  = 4'h8,
      LMP_CMD_PDN   = 4'h9,
      LMP_CMD_DPD   = 4'ha
   } lmp_cmd_t;
   // ZQ calibration flavours
   typedef enum logic [1:0] {
      LMP_ZQ_INIT  = 2'b00,
      LMP_ZQ_SHORT = 2'b01,
      LMP_ZQ_LONG  = 2'b10,
      LMP_ZQ_RESET = 2'b11
   } lmp_zq_t;
   // Latencies and burst figures
   localparam int RL        = 6;
   localparam int WL        = 3;
   localparam int MRR_BEATS = 4;
   localparam int BL_DEF    = 8;
   localparam int CLK_STABLE = 2;
   // Timing values in nanoseconds (TMRR_CYC, TMRW_CYC in cycles), as printed or plain defaults
   localparam int TDQSCK_MAX_NS = 6;
   localparam int TWTR_NS       = 8;
   localparam int TMRR_CYC      = 2;
   localparam int TMRW_CYC      = 5;
   localparam int TXSR_NS       = 140;
   localparam int TIHCKE_NS     = 1;
   localparam int TZQINIT_NS    = 1000;
   localparam int TZQCS_NS      = 90;
   localparam int TZQCL_NS      = 360;
   localparam int TZQRESET_NS   = 50;
   // Derived cycle counts (least times round up)
   localparam int CLK_NS = CLK_PERIOD_PS / 1000;
   localparam int TDQSCK_CYC  = (TDQSCK_MAX_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWTR_CYC    = (TWTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int TXSR_CYC    = (TXSR_NS + CLK_NS - 1) / CLK_NS;
   localparam int TIHCKE_CYC  = (TIHCKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TZQINIT_CYC = (TZQINIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int TZQCS_CYC   = (TZQCS_NS + CLK_NS - 1) / CLK_NS;
   localparam int TZQCL_CYC   = (TZQCL_NS + CLK_NS - 1) / CLK_NS;
   localparam int TZQRST_CYC  = (TZQRESET_NS + CLK_NS - 1) / CLK_NS;
   // Command spacings in cycles
   localparam int MRR_TO_WR  = RL + TDQSCK_CYC + MRR_BEATS / 2 + 1 - WL;
   localparam int MRR_TO_MRW = RL + TDQSCK_CYC + MRR_BEATS / 2 + 1;
   localparam int MRR_TO_PD  = RL + TDQSCK_CYC + MRR_BEATS / 2 + 1;
   // Calibration-pattern register addresses
   localparam logic [7:0] MR_CAL_A = 8'h20;
   localparam logic [7:0] MR_CAL_B = 8'h28;
   // Counter width
   localparam int CNT_W = 8;
endpackage : lmp_pkg

// >>> lmp_if.sv
// Link between memory controller and memory device command model.
// Assumes both ends share clk_sys_i; data lines are resolved here.
interface lmp_if;
   import lmp_pkg::*;
   lmp_cmd_t    cmd;        // Command, one cycle per command
   lmp_zq_t     zq_kind;    // ZQ flavour with LMP_CMD_ZQ
   logic [7:0]  mr_addr;    // Mode register address
   logic [7:0]  mr_wdata;   // Mode register write data
   logic        cke;        // Clock enable level
   logic [31:0] dq_dev;     // Device data out
   logic        dq_dev_oe;  // Device drives data lines
   logic        dq_valid;   // Device data beat strobe
   logic [31:0] dq;         // Resolved bus level
   assign dq = dq_dev_oe ? dq_dev : 32'h0000_0000;
   modport ctrl (output cmd, zq_kind, mr_addr, mr_wdata, cke,
                 input dq, dq_valid);
   modport dev  (input cmd, zq_kind, mr_addr, mr_wdata, cke,
                 output dq_dev, dq_dev_oe, dq_valid);
endinterface : lmp_if

// >>> lmp_dev.sv
// Memory device end: mode registers, MRR bursts, power state tracking.
// Assumes the controller keeps all command spacing rules.
module lmp_dev
   import lmp_pkg::*;
#(
   parameter bit CAL_COPY = 1'b1   // Calibration: copy bit 0 or drive 0b
)(
   input  wire logic         clk_sys_i,   // System clock
   input  wire logic         reset_i,     // Async reset, active high
   lmp_if.dev                link,        // Controller link
   output logic              idle_o,      // Device idle
   output logic              sref_o,      // In self-refresh
   output logic              pdn_o        // In power-down or deep
);
   import lmp_pkg::*;
   // Device states
   typedef enum logic [2:0] {
      LMP_D_IDLE = 3'b000,
      LMP_D_MRW  = 3'b001,
      LMP_D_SREF = 3'b010,
      LMP_D_PDN  = 3'b011,
      LMP_D_DPD  = 3'b100,
      LMP_D_ZQ   = 3'b101
   } lmp_dst_t;
   lmp_dst_t           st_r, st_nxt;        // State
   logic [CNT_W-1:0]   cnt_r, cnt_nxt;      // Busy counter
   logic [7:0]         mr_r [256];          // Mode register array
   logic [7:0]         rd_r, rd_nxt;        // Latched MRR data
   logic               cal_r, cal_nxt;      // Pattern register read
   logic [3:0]         lat_r, lat_nxt;      // Read latency counter
   logic [2:0]         beat_r, beat_nxt;    // Remaining beats
   logic [1:0]         bidx_r, bidx_nxt;    // Beat index
   logic [31:0]        dq_r, dq_nxt;        // Data out
   logic               oe_r, oe_nxt;        // Output enable
   logic               pend_r, pend_nxt;    // Burst pending
   // Next-state logic
   always_comb begin
      logic bitv;
      bitv     = 1'b0;
      st_nxt   = st_r;
      cnt_nxt  = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      rd_nxt   = rd_r;
      cal_nxt  = cal_r;
      lat_nxt  = lat_r;
      beat_nxt = beat_r;
      bidx_nxt = bidx_r;
      dq_nxt   = dq_r;
      oe_nxt   = 1'b0;
      pend_nxt = pend_r;
      case (st_r)
         LMP_D_IDLE: begin
            if (link.cmd == LMP_CMD_MRR) begin
               // Capture register; start latency unless a burst is already pending
               rd_nxt   = mr_r[link.mr_addr];
               cal_nxt  = (link.mr_addr == MR_CAL_A) ||
                          (link.mr_addr == MR_CAL_B);
               lat_nxt  = 4'(RL - 1);
               pend_nxt = 1'b1;
            end else if (link.cmd == LMP_CMD_MRW) begin
               st_nxt  = LMP_D_MRW;
               cnt_nxt = CNT_W'(TMRW_CYC - 2); // Idle as the period ends
            end else if (link.cmd == LMP_CMD_ZQ) begin
               st_nxt  = LMP_D_ZQ;
               cnt_nxt = '1;
            end else if (link.cmd == LMP_CMD_SREF) begin
               st_nxt = LMP_D_SREF;
            end else if (link.cmd == LMP_CMD_PDN) begin
               st_nxt = LMP_D_PDN;
            end else if (link.cmd == LMP_CMD_DPD) begin
               st_nxt = LMP_D_DPD;
            end
         end
         LMP_D_MRW: begin
            // Back to idle once the write period ends
            if (cnt_r == '0) begin
               st_nxt = LMP_D_IDLE;
            end
         end
         LMP_D_ZQ: begin
            // Calibration; data drivers off throughout
            if (link.cmd != LMP_CMD_NOP) begin
               st_nxt = LMP_D_IDLE;
            end
         end
         LMP_D_SREF, LMP_D_PDN, LMP_D_DPD: begin
            // Leave low-power state when clock enable rises
            if (link.cke) begin
               st_nxt = LMP_D_IDLE;
            end
         end
         default: begin
            st_nxt = LMP_D_IDLE;
         end
      endcase
      // Read burst engine: fixed four beats
      if (pend_r) begin
         if (lat_r != 4'h0) begin
            lat_nxt = lat_r - 1'b1;
         end else begin
            pend_nxt = 1'b0;
            beat_nxt = 3'(MRR_BEATS);
            bidx_nxt = 2'b00;
         end
      end
      if (beat_r != 3'b000) begin
         beat_nxt = beat_r - 1'b1;
         bidx_nxt = bidx_r + 1'b1;
         oe_nxt   = 1'b1;
         bitv     = rd_r[bidx_r];
         if (cal_r) begin
            // Pattern bit on lines 0,8,16,24
            dq_nxt = {4{7'h00, bitv}};
            if (CAL_COPY) begin
               dq_nxt = {32{bitv}};
            end
         end else if (bidx_r == 2'b00) begin
            dq_nxt = {24'h00_0000, rd_r};
         end else begin
            dq_nxt = 32'h0000_0000;
         end
      end
   end
   // State registers
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         st_r   <= LMP_D_IDLE;
         cnt_r  <= '0;
         rd_r   <= 8'h00;
         cal_r  <= 1'b0;
         lat_r  <= 4'h0;
         beat_r <= 3'b000;
         bidx_r <= 2'b00;
         dq_r   <= 32'h0000_0000;
         oe_r   <= 1'b0;
         pend_r <= 1'b0;
         idle_o <= 1'b1;
         sref_o <= 1'b0;
         pdn_o  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         rd_r   <= rd_nxt;
         cal_r  <= cal_nxt;
         lat_r  <= lat_nxt;
         beat_r <= beat_nxt;
         bidx_r <= bidx_nxt;
         dq_r   <= dq_nxt;
         oe_r   <= oe_nxt;
         pend_r <= pend_nxt;
         idle_o <= (st_nxt == LMP_D_IDLE);
         sref_o <= (st_nxt == LMP_D_SREF);
         pdn_o  <= (st_nxt == LMP_D_PDN) || (st_nxt == LMP_D_DPD);
      end
   end
   // Mode register array write
   always_ff @(posedge clk_sys_i) begin
      if (st_r == LMP_D_IDLE && link.cmd == LMP_CMD_MRW) begin
         mr_r[link.mr_addr] <= link.mr_wdata;
      end
   end
   assign link.dq_dev    = dq_r;
   assign link.dq_dev_oe = oe_r;
   assign link.dq_valid  = oe_r;
endmodule : lmp_dev

// >>> lmp_ctrl.sv
// Controller end: issues commands and holds off until spacing is met.
// Assumes the device model answers on the shared link interface.
// Functional notes
// - Mode register read bursts are always four
// - Never interrupt a mode register read (a second mode read three cycles later keeps the first burst's timing but swaps in its own register data)
// - Register data on low byte, first beat
// - Only no-ops during mode read period
// - Read-to-write spacing after mode register read
// - Read-to-mode-write spacing after mode register read
// - Two stable clocks before self-refresh exit
// - All banks precharged before self-refresh
// - No-ops only during self-refresh exit time
// - Mode read at least BL/2 after read
// - Mode read spacing after a write
// - Pattern registers drive line 0 every beat
// - Other pattern lines copy or zero
// - No-ops during mode write period, then idle
// - No-ops during each ZQ calibration period
// - Clock enable held high during calibration
// - Data drivers off during calibration
// - Two stable clocks before power-down exit
// - Read-to-power-down spacing
// - Mode-read-to-power-down spacing
// - Activate/precharge to power-down after tIHCKE
// - Two stable clocks, then reinitialise after deep
module lmp_ctrl
   import lmp_pkg::*;
#(
   parameter int BL = BL_DEF    // Programmed burst length
)(
   input  wire logic         clk_sys_i,    // System clock
   input  wire logic         reset_i,      // Async reset, active high
   lmp_if.ctrl               link,         // Device link
   input  wire lmp_cmd_t     req_cmd_i,    // Requested command
   input  wire lmp_zq_t      req_zq_i,     // Requested ZQ flavour
   input  wire logic [7:0]   req_addr_i,   // Mode register address
   input  wire logic [7:0]   req_wdata_i,  // Mode register data
   input  wire logic         req_valid_i,  // Request present
   input  wire logic         wake_i,       // Leave low-power state
   output logic              req_ready_o,  // Request taken this cycle
   output logic              reinit_o,     // Deep exit: reinitialise
   output logic [7:0]        mr_data_o,    // Mode register read data
   output logic              mr_valid_o    // Read data pulse
);
   import lmp_pkg::*;
   lmp_cmd_t          cmd_r, cmd_nxt;       // Command out
   lmp_zq_t           zq_r, zq_nxt;         // ZQ flavour out
   logic [7:0]        addr_r, addr_nxt;     // Address out
   logic [7:0]        wd_r, wd_nxt;         // Write data out
   logic              cke_r, cke_nxt;       // Clock enable out
   logic [CNT_W-1:0]  nop_r, nop_nxt;       // No-op only window
   logic [CNT_W-1:0]  wr_r, wr_nxt;         // Wait before write
   logic [CNT_W-1:0]  mrw_r, mrw_nxt;       // Wait before mode write
   logic [CNT_W-1:0]  mrr_r, mrr_nxt;       // Wait before mode read
   logic [CNT_W-1:0]  pd_r, pd_nxt;         // Wait before power-down
   logic [1:0]        stab_r, stab_nxt;     // Stable clocks counted
   logic              lowp_r, lowp_nxt;     // In low-power state
   logic              deep_r, deep_nxt;     // Low power is deep
   logic              rdy_r, rdy_nxt;       // Ready pulse
   logic              rei_r, rei_nxt;       // Reinit pulse
   logic [7:0]        md_r, md_nxt;         // Captured read data
   logic              mv_r, mv_nxt;         // Captured pulse
   logic              first_r, first_nxt;   // Expecting first beat
   logic              open_r, open_nxt;     // A bank may be open
   // Decrement helper
   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      dec = (v != '0) ? v - 1'b1 : v;
   endfunction : dec
   // Raise a wait counter to at least a value
   function automatic logic [CNT_W-1:0] atl(input logic [CNT_W-1:0] v,
                                            input int n);
      atl = (v > CNT_W'(n)) ? v : CNT_W'(n);
   endfunction : atl
   // Command decision
   always_comb begin
      logic ok;
      ok        = 1'b0;
      cmd_nxt   = LMP_CMD_NOP;
      zq_nxt    = zq_r;
      addr_nxt  = addr_r;
      wd_nxt    = wd_r;
      cke_nxt   = cke_r;
      nop_nxt   = dec(nop_r);
      wr_nxt    = dec(wr_r);
      mrw_nxt   = dec(mrw_r);
      mrr_nxt   = dec(mrr_r);
      pd_nxt    = dec(pd_r);
      stab_nxt  = stab_r;
      lowp_nxt  = lowp_r;
      deep_nxt  = deep_r;
      rdy_nxt   = 1'b0;
      rei_nxt   = 1'b0;
      md_nxt    = md_r;
      mv_nxt    = 1'b0;
      first_nxt = first_r;
      open_nxt  = open_r;
      if (lowp_r) begin
         // Count stable clocks before exit
         if (wake_i && stab_r < 2'(CLK_STABLE)) begin
            stab_nxt = stab_r + 1'b1;
         end else if (wake_i) begin
            cke_nxt  = 1'b1;
            lowp_nxt = 1'b0;
            stab_nxt = 2'b00;
            rei_nxt  = deep_r;
            nop_nxt  = CNT_W'(TXSR_CYC);
         end
      end else if (req_valid_i && nop_r == '0) begin
         // No-op windows block all commands
         case (req_cmd_i)
            LMP_CMD_WRITE: ok = (wr_r == '0);
            LMP_CMD_MRW:   ok = (mrw_r == '0);
            LMP_CMD_MRR:   ok = (mrr_r == '0);
            LMP_CMD_ZQ:    ok = (pd_r == '0);   // Burst over
            LMP_CMD_SREF:  ok = (pd_r == '0) && !open_r;
            LMP_CMD_PDN, LMP_CMD_DPD:
               ok = (pd_r == '0);
            default:       ok = 1'b1;
         endcase
      end
      if (ok) begin
         cmd_nxt  = req_cmd_i;
         zq_nxt   = req_zq_i;
         addr_nxt = req_addr_i;
         wd_nxt   = req_wdata_i;
         rdy_nxt  = 1'b1;
         case (req_cmd_i)
            LMP_CMD_READ: begin
               mrr_nxt = atl(mrr_nxt, BL / 2);
               pd_nxt  = atl(pd_nxt, RL + TDQSCK_CYC + BL / 2 + 1);
            end
            LMP_CMD_WRITE: begin
               mrr_nxt = atl(mrr_nxt, WL + 1 + BL / 2 + TWTR_CYC);
               pd_nxt  = atl(pd_nxt, WL + 1 + BL / 2 + TWTR_CYC);
            end
            LMP_CMD_ACT, LMP_CMD_PRE: begin
               pd_nxt = atl(pd_nxt, TIHCKE_CYC);
               open_nxt = (req_cmd_i == LMP_CMD_ACT);
            end
            LMP_CMD_MRR: begin
               // Burst runs on at its first timing; a further mode read three cycles later only swaps in its register data
               nop_nxt   = CNT_W'(TMRR_CYC - 1);
               wr_nxt    = atl(wr_nxt, MRR_TO_WR);
               mrw_nxt   = atl(mrw_nxt, MRR_TO_MRW);
               mrr_nxt   = atl(mrr_nxt, MRR_BEATS / 2);
               pd_nxt    = atl(pd_nxt, MRR_TO_PD);
               first_nxt = 1'b1;
            end
            LMP_CMD_MRW: begin
               nop_nxt = CNT_W'(TMRW_CYC - 1);
            end
            LMP_CMD_ZQ: begin
               // Clock enable stays high; cke_r untouched
               case (req_zq_i)
                  LMP_ZQ_INIT:  nop_nxt = CNT_W'(TZQINIT_CYC);
                  LMP_ZQ_SHORT: nop_nxt = CNT_W'(TZQCS_CYC);
                  LMP_ZQ_LONG:  nop_nxt = CNT_W'(TZQCL_CYC);
                  default:      nop_nxt = CNT_W'(TZQRST_CYC);
               endcase
            end
            LMP_CMD_SREF, LMP_CMD_PDN, LMP_CMD_DPD: begin
               cke_nxt  = 1'b0;
               lowp_nxt = 1'b1;
               deep_nxt = (req_cmd_i == LMP_CMD_DPD);
            end
            default: begin
               nop_nxt = nop_nxt;
            end
         endcase
      end
      // Capture first beat of a mode register read
      if (link.dq_valid && first_r) begin
         md_nxt    = link.dq[7:0];
         mv_nxt    = 1'b1;
         first_nxt = ok && (req_cmd_i == LMP_CMD_MRR); // New read wins
      end
   end
   // Registers
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cmd_r   <= LMP_CMD_NOP;
         zq_r    <= LMP_ZQ_INIT;
         addr_r  <= 8'h00;
         wd_r    <= 8'h00;
         cke_r   <= 1'b1;
         nop_r   <= '0;
         wr_r    <= '0;
         mrw_r   <= '0;
         mrr_r   <= '0;
         pd_r    <= '0;
         stab_r  <= 2'b00;
         lowp_r  <= 1'b0;
         deep_r  <= 1'b0;
         rdy_r   <= 1'b0;
         rei_r   <= 1'b0;
         md_r    <= 8'h00;
         mv_r    <= 1'b0;
         first_r <= 1'b0;
         open_r  <= 1'b0;
      end else begin
         cmd_r   <= cmd_nxt;
         zq_r    <= zq_nxt;
         addr_r  <= addr_nxt;
         wd_r    <= wd_nxt;
         cke_r   <= cke_nxt;
         nop_r   <= nop_nxt;
         wr_r    <= wr_nxt;
         mrw_r   <= mrw_nxt;
         mrr_r   <= mrr_nxt;
         pd_r    <= pd_nxt;
         stab_r  <= stab_nxt;
         lowp_r  <= lowp_nxt;
         deep_r  <= deep_nxt;
         rdy_r   <= rdy_nxt;
         rei_r   <= rei_nxt;
         md_r    <= md_nxt;
         mv_r    <= mv_nxt;
         first_r <= first_nxt;
         open_r  <= open_nxt;
      end
   end
   assign link.cmd      = cmd_r;
   assign link.zq_kind  = zq_r;
   assign link.mr_addr  = addr_r;
   assign link.mr_wdata = wd_r;
   assign link.cke      = cke_r;
   assign req_ready_o   = rdy_r;
   assign reinit_o      = rei_r;
   assign mr_data_o     = md_r;
   assign mr_valid_o    = mv_r;
endmodule : lmp_ctrl

// >>> lmp_chk.sv
// Checker: command spacing and burst shape on the controller/device link.
// Assumes one clock and the link signals of a single pair as inputs.
module lmp_chk
   import lmp_pkg::*;
(
   input  wire logic        clk_sys_i,  // System clock
   input  wire logic        reset_i,    // Async reset, active high
   input  wire lmp_cmd_t    cmd,        // Command on the link
   input  wire lmp_zq_t     zq_kind,    // ZQ flavour
   input  wire logic [7:0]  mr_addr,    // Mode register address
   input  wire logic        cke,        // Clock enable
   input  wire logic        dq_dev_oe,  // Device drives data
   input  wire logic        dq_valid,   // Data beat strobe
   input  wire logic [31:0] dq          // Resolved data lines
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sref_r;  // Self-refresh entered, exit still to come
   logic cal_w;   // Mode read of a calibration-pattern register
   assign cal_w = cmd == LMP_CMD_MRR && (mr_addr == MR_CAL_A ||
                                         mr_addr == MR_CAL_B);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // Remember self-refresh until clock enable comes back
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) sref_r <= 1'b0;
      else if (cmd == LMP_CMD_SREF) sref_r <= 1'b1;
      else if ($rose(cke)) sref_r <= 1'b0;
   end
   chk_mrr_nop: assert property (
      cmd == LMP_CMD_MRR |=> cmd == LMP_CMD_NOP)
      else $error("command inside mode read period");
   chk_mrr_burst: assert property (
      cmd == LMP_CMD_MRR |-> ##8 dq_valid [*4] ##1 !dq_valid)
      else $error("mode read burst not four beats");
   chk_cal_lane0: assert property (
      cal_w |-> ##8 (dq[8] == dq[0] && dq[16] == dq[0] &&
                     dq[24] == dq[0] && dq_dev_oe) [*4])
      else $error("pattern not mirrored on lanes");
   chk_cal_fill: assert property (
      cal_w |-> ##8 (dq[7:1] == 7'h00 || dq[7:1] == {7{dq[0]}}) [*4])
      else $error("pattern fill lines wrong");
   chk_mrr_write: assert property (
      cmd == LMP_CMD_MRR |=>
         (cmd != LMP_CMD_WRITE && cmd != LMP_CMD_READ) [*6])
      else $error("write or read too soon after mode read");
   chk_mrr_mrw_pd: assert property (
      cmd == LMP_CMD_MRR |=> (cmd != LMP_CMD_MRW && cke) [*8]
         ##1 (cmd != LMP_CMD_MRW && cke))
      else $error("mode write or power-down too soon");
   chk_mrw_nop: assert property (
      cmd == LMP_CMD_MRW |=> (cmd == LMP_CMD_NOP) [*4])
      else $error("command inside mode write period");
   chk_rd_mrr: assert property (
      cmd == LMP_CMD_READ |=> (cmd != LMP_CMD_MRR) [*3])
      else $error("mode read too soon after read");
   chk_wr_mrr: assert property (
      cmd == LMP_CMD_WRITE |=> (cmd != LMP_CMD_MRR) [*8])
      else $error("mode read too soon after write");
   chk_rd_pd: assert property (
      cmd == LMP_CMD_READ |=> cke [*8] ##1 cke [*3])
      else $error("power-down too soon after read");
   chk_zq_quiet: assert property (
      cmd == LMP_CMD_ZQ && zq_kind == LMP_ZQ_SHORT |=>
         (cmd == LMP_CMD_NOP && cke && !dq_dev_oe) [*4])
      else $error("short calibration period disturbed");
   chk_sref_exit: assert property (
      sref_r && $rose(cke) |-> (cmd == LMP_CMD_NOP) [*7])
      else $error("command inside self-refresh exit time");
endmodule : lmp_chk

// >>> lmp_tb.sv
// Testbench: controller and device joined by the link, driven by requests.
// Assumes a 50 MHz clock; spacing figures come from the shared package.
module lmp_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lmp_pkg::*;
   localparam logic [31:0] YES   = 32'h0000_0001; // True as compare value
   localparam int          LIMIT = 5000;          // Cycle ceiling
   // Command pairs and the least spacing between them
   localparam lmp_cmd_t FST[8] = '{LMP_CMD_MRR, LMP_CMD_MRR, LMP_CMD_MRR,
      LMP_CMD_READ, LMP_CMD_WRITE, LMP_CMD_READ, LMP_CMD_ACT, LMP_CMD_PRE};
   localparam lmp_cmd_t SND[8] = '{LMP_CMD_WRITE, LMP_CMD_MRW, LMP_CMD_PDN,
      LMP_CMD_MRR, LMP_CMD_MRR, LMP_CMD_PDN, LMP_CMD_PDN, LMP_CMD_PDN};
   localparam int GAP[8] = '{MRR_TO_WR, MRR_TO_MRW, MRR_TO_PD, BL_DEF / 2,
      WL + 1 + BL_DEF / 2 + TWTR_CYC, RL + TDQSCK_CYC + BL_DEF / 2 + 1,
      TIHCKE_CYC, TIHCKE_CYC};
   localparam lmp_zq_t ZQK[4] = '{LMP_ZQ_INIT, LMP_ZQ_SHORT, LMP_ZQ_LONG,
                                  LMP_ZQ_RESET};
   localparam int ZQC[4] = '{TZQINIT_CYC, TZQCS_CYC, TZQCL_CYC, TZQRST_CYC};
   logic       clk_sys_i, reset_i, req_valid_i, wake_i;  // Bench drives
   logic       req_ready_o, reinit_o, mr_valid_o;        // Controller out
   logic       idle_o, sref_o, pdn_o;                    // Device state
   lmp_cmd_t   req_cmd_i;                                // Requested command
   lmp_zq_t    req_zq_i;                                 // Requested flavour
   logic [7:0] req_addr_i, req_wdata_i, mr_data_o;       // Register traffic
   int         cyc = 0, tk, t0, reinit_cnt = 0;          // Cycle bookkeeping
   int         failures = 0, samples_checked = 0;        // Report counters
   lmp_if u_lmp_if ();
   lmp_ctrl u_lmp_ctrl (.clk_sys_i, .reset_i, .link(u_lmp_if.ctrl),
      .req_cmd_i, .req_zq_i, .req_addr_i, .req_wdata_i, .req_valid_i,
      .wake_i, .req_ready_o, .reinit_o, .mr_data_o, .mr_valid_o);
   lmp_dev u_lmp_dev (.clk_sys_i, .reset_i, .link(u_lmp_if.dev),
      .idle_o, .sref_o, .pdn_o);
   lmp_chk u_lmp_chk (.clk_sys_i, .reset_i, .cmd(u_lmp_if.cmd),
      .zq_kind(u_lmp_if.zq_kind), .mr_addr(u_lmp_if.mr_addr),
      .cke(u_lmp_if.cke), .dq_dev_oe(u_lmp_if.dq_dev_oe),
      .dq_valid(u_lmp_if.dq_valid), .dq(u_lmp_if.dq));
   // Free-running system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // Cycle count, reinit pulse count and hang cut-off
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (reinit_o === 1'b1) reinit_cnt <= reinit_cnt + 1;
      if (cyc == LIMIT) begin
         failures++;
         close_out();
      end
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Wait edges, then settle past the launching edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : tick
   // Hold one request until the controller takes it
   task automatic issue(input lmp_cmd_t c, input logic [7:0] a = 8'h03,
                        input lmp_zq_t z = LMP_ZQ_INIT);
      int n;
      n = 0;
      tick(1);
      req_cmd_i = c;
      req_zq_i = z;
      req_addr_i = a;
      req_wdata_i = 8'ha5;
      req_valid_i = 1'b1;
      do begin
         tick(1);
         n++;
      end while (req_ready_o !== 1'b1 && n < 200);
      check({31'h0, req_ready_o}, YES);
      tk = cyc;
      req_valid_i = 1'b0;
   endtask : issue
   // Wait for a mode read result under a bound
   task automatic wait_mr;
      t0 = cyc;
      do tick(1);
      while (mr_valid_o !== 1'b1 && cyc - t0 < 50);
   endtask : wait_mr
   // Leave a low-power state; clock enable must not return at once
   task automatic leave_lp;
      t0 = cyc;
      wake_i = 1'b1;
      do tick(1);
      while (u_lmp_if.cke !== 1'b1 && cyc - t0 < 100);
      check(32'(cyc - t0 >= CLK_STABLE), YES);
      wake_i = 1'b0;
   endtask : leave_lp
   // Print counts and verdict, then stop
   task automatic close_out;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      {req_valid_i, wake_i, req_addr_i, req_wdata_i} = 18'h0_0000;
      req_cmd_i = LMP_CMD_NOP;
      req_zq_i = LMP_ZQ_INIT;
      reset_i = 1'b1;
      tick(10);
      reset_i = 1'b0;
      // State out of reset: cke, idle high; others low
      check(32'({u_lmp_if.cke, idle_o, sref_o, pdn_o, u_lmp_if.dq_dev_oe}),
            32'h0000_0018);
      // Write a mode register, then read it back
      issue(LMP_CMD_MRW);
      tick(TMRW_CYC + 1);
      check({31'h0, idle_o}, YES);
      issue(LMP_CMD_MRR);
      wait_mr();
      check(32'(cyc - tk), 32'(RL + 3));
      check({24'h0, mr_data_o}, 32'h0000_00a5);
      // Spacing between command pairs, power-down exits included
      for (int i = 0; i < 8; i++) begin
         issue(FST[i]);
         t0 = tk;
         issue(SND[i]);
         check(32'(tk - t0 >= GAP[i]), YES);
         if (SND[i] == LMP_CMD_PDN) begin
            tick(2);
            check({31'h0, pdn_o}, YES);
            leave_lp();
         end
      end
      // Each calibration flavour holds off the next command
      for (int k = 0; k < 4; k++) begin
         issue(LMP_CMD_ZQ, 8'h00, ZQK[k]);
         t0 = tk;
         issue(LMP_CMD_PRE);
         check(32'(tk - t0 >= ZQC[k]), YES);
      end
      // Pattern registers loaded with bit 0 set; copy mode fills the byte
      for (int j = 0; j < 2; j++) begin
         issue(LMP_CMD_MRW, j ? MR_CAL_B : MR_CAL_A);
         issue(LMP_CMD_MRR, j ? MR_CAL_B : MR_CAL_A);
         wait_mr();
         check({24'h0, mr_data_o}, 32'h0000_00ff);
      end
      // Self-refresh with all banks closed, then exit
      issue(LMP_CMD_PRE);
      issue(LMP_CMD_SREF);
      tick(4);
      check(32'({u_lmp_if.cke, sref_o}), 32'h0000_0001);
      leave_lp();
      t0 = cyc;
      issue(LMP_CMD_ACT);
      check(32'(tk - t0 >= TXSR_CYC), YES);
      // Self-refresh stays refused while that bank is open
      tick(1);
      req_cmd_i = LMP_CMD_SREF;
      req_valid_i = 1'b1;
      tick(20);
      check(32'({u_lmp_if.cke, sref_o}), 32'h0000_0002);
      req_valid_i = 1'b0;
      // Deep power-down, exit and one reinit request
      issue(LMP_CMD_DPD);
      tick(4);
      check({31'h0, pdn_o}, YES);
      leave_lp();
      tick(20);
      check(32'(reinit_cnt), YES);
      close_out();
   end
endmodule : lmp_tb
